// file: core/apmc_cfg.svh
`ifndef APMC_CFG_SVH
`define APMC_CFG_SVH

// register map, 6-bit address space of the serial register port
`define APMC_ADDR_INACT_THRESH   6'h25
`define APMC_ADDR_INACT_DUR      6'h26
`define APMC_ADDR_RATE_SELECT    6'h2C
`define APMC_ADDR_POWER_CONTROL  6'h2D

// reset values
`define APMC_RST_INACT_THRESH    8'h00
`define APMC_RST_INACT_DUR       8'h00
`define APMC_RST_RATE_SELECT     8'h0A
`define APMC_RST_POWER_CONTROL   8'h00

// field positions
`define APMC_BIT_LOW_POWER       4
`define APMC_RATE_LSB            0
`define APMC_RATE_MSB            3
`define APMC_BIT_LINK            5
`define APMC_BIT_AUTO_SLEEP      4
`define APMC_BIT_MEASURE         3
`define APMC_BIT_SLEEP_STATE     2

// timing: clock rate and base sample rate, both in hertz
`define APMC_CLK_HZ              32'h0131_2D00
`define APMC_BASE_HZ             32'h0000_0C80
// rate code of the fastest output rate, the base rate
`define APMC_TOP_CODE            4'hF
// sleep divider shift: base rate / 2^9, below 8 Hz
`define APMC_SLEEP_SHIFT         4'h9
// reduced-power window of rate codes
`define APMC_LP_CODE_MIN         4'h7
`define APMC_LP_CODE_MAX         4'hC

`endif

// file: core/apmc_pkg.sv
`include "apmc_cfg.svh"

package apmc_pkg;

    // power states of the sensor core
    typedef enum logic [1:0] {
        APMC_STANDBY,
        APMC_MEASURE,
        APMC_SLEEP
    } apmc_state_t;

    // divider shift that turns the base rate into the coded output rate
    function automatic logic [3:0] apmc_rate_shift(input logic [3:0] code);
        apmc_rate_shift = `APMC_TOP_CODE - code;
    endfunction

    // codes for which reduced-power sampling pays off
    function automatic logic apmc_lp_code(input logic [3:0] code);
        apmc_lp_code = (code >= `APMC_LP_CODE_MIN) && (code <= `APMC_LP_CODE_MAX);
    endfunction

endpackage

// file: core/apmc_rate_div.sv
// divides the base sample tick by 2^shift; restarts whenever run drops
module apmc_rate_div (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       base_tick,
    input  wire logic [3:0] shift,
    output logic            tick
);

    logic [15:0] cnt;    // base ticks seen in this period
    wire  [15:0] limit;  // last count of the period

    assign limit = (16'h0001 << shift) - 16'h0001;

    // count base ticks, emit one pulse per period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt  <= 16'h0000;
                tick <= 1'b0;
            end else if (base_tick) begin
                // a shift change mid-period may overrun the limit; >= recovers
                cnt  <= (cnt >= limit) ? 16'h0000 : cnt + 16'h0001;
                tick <= (cnt >= limit);
            end else begin
                tick <= 1'b0;
            end
        end
    end

endmodule

// file: core/apmc_top.sv
`include "apmc_cfg.svh"

module apmc_top
    import apmc_pkg::*;
#(
    parameter int BASE_DIV      = `APMC_CLK_HZ / `APMC_BASE_HZ,  // clocks per base tick
    parameter int TICKS_PER_SEC = `APMC_BASE_HZ                  // base ticks per second
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       sample_valid,
    input  wire logic [7:0] sample_mag_x,
    input  wire logic [7:0] sample_mag_y,
    input  wire logic [7:0] sample_mag_z,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    output logic            sensing_on,
    output logic            asleep,
    output logic            low_power_active,
    output logic            sample_req,
    output logic            store_write_en
);

    // register file
    // four byte-wide registers; only host writes change them, so a
    // power-state move can never disturb the stored configuration
    logic [7:0]  inactivity_threshold;  // no-activity level
    logic [7:0]  inactivity_duration;   // seconds of quiet before sleep
    logic [7:0]  rate_select;           // reduced-power bit and rate code
    logic [7:0]  power_control;         // link, auto-sleep, measure bits

    // address decode, one select per register
    wire         sel_thresh;
    wire         sel_dur;
    wire         sel_rate;
    wire         sel_power;
    assign sel_thresh = (reg_addr == `APMC_ADDR_INACT_THRESH);
    assign sel_dur    = (reg_addr == `APMC_ADDR_INACT_DUR);
    assign sel_rate   = (reg_addr == `APMC_ADDR_RATE_SELECT);
    assign sel_power  = (reg_addr == `APMC_ADDR_POWER_CONTROL);

    // field views of the control registers
    wire         measure_bit;
    wire         auto_sleep_bit;
    wire         link_bit;
    wire         low_power_bit;
    wire  [3:0]  rate_code;
    assign measure_bit    = power_control[`APMC_BIT_MEASURE];
    assign auto_sleep_bit = power_control[`APMC_BIT_AUTO_SLEEP];
    assign link_bit       = power_control[`APMC_BIT_LINK];
    assign low_power_bit  = rate_select[`APMC_BIT_LOW_POWER];
    assign rate_code      = rate_select[`APMC_RATE_MSB:`APMC_RATE_LSB];

    // state register of the power sequencer
    apmc_state_t state;
    apmc_state_t next_state;

    // power_control reads back the written bits, with the sleep flag
    // showing the live state; the flag is status only, not storage
    wire  [7:0]  power_view;
    assign power_view = (state == APMC_SLEEP)
                      ? (power_control | (8'h01 << `APMC_BIT_SLEEP_STATE))
                      : (power_control & ~(8'h01 << `APMC_BIT_SLEEP_STATE));

    // read mux; unmapped addresses read as zero
    wire  [7:0]  read_mux;
    assign read_mux = sel_thresh ? inactivity_threshold :
                      sel_dur    ? inactivity_duration  :
                      sel_rate   ? rate_select          :
                      sel_power  ? power_view           : 8'h00;

    // register writes; no state is checked, so standby and sleep both
    // accept configuration, and only software ever changes these bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inactivity_threshold <= `APMC_RST_INACT_THRESH;
            inactivity_duration  <= `APMC_RST_INACT_DUR;
            rate_select          <= `APMC_RST_RATE_SELECT;
            power_control        <= `APMC_RST_POWER_CONTROL;
        end else if (ce && reg_wr) begin
            if (sel_thresh) begin
                inactivity_threshold <= reg_wdata;
            end
            if (sel_dur) begin
                inactivity_duration <= reg_wdata;
            end
            if (sel_rate) begin
                rate_select <= reg_wdata;
            end
            if (sel_power) begin
                // the sleep flag position is status; keep it clear here
                power_control <= reg_wdata & ~(8'h01 << `APMC_BIT_SLEEP_STATE);
            end
        end
    end

    // read data, registered one cycle after the strobe
    // reg_rdata holds between reads so a slow host can sample late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_mux;
            end
        end
    end

    // base sample clock and output-rate divider
    // the prescaler makes the base rate, the divider picks one tick
    // in every power-of-two block of base ticks for the output rate
    logic [15:0] base_cnt;   // clocks within one base tick
    logic        base_tick;  // one pulse per base period
    wire         running;    // sensing core powered
    assign running = (state != APMC_STANDBY);

    // the prescaler halts in standby: nothing ticks, nothing sampled
    // and it restarts from zero, so the first tick is a full period late
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            base_cnt  <= 16'h0000;
            base_tick <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                base_cnt  <= 16'h0000;
                base_tick <= 1'b0;
            end else begin
                base_tick <= (base_cnt == 16'(BASE_DIV - 1));
                base_cnt  <= (base_cnt == 16'(BASE_DIV - 1)) ? 16'h0000 : base_cnt + 16'h0001;
            end
        end
    end

    // divider shift: coded rate while measuring, slow rate while asleep
    wire  [3:0]  div_shift;
    assign div_shift = (state == APMC_SLEEP) ? `APMC_SLEEP_SHIFT
                                             : apmc_rate_shift(rate_code);

    // the divider restarts together with the prescaler when the core stops
    wire         rate_tick;  // one pulse per output sample
    apmc_rate_div u_rate_div (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .run       (running),
        .base_tick (base_tick),
        .shift     (div_shift),
        .tick      (rate_tick)
    );

    // reduced power only takes effect on codes where it saves anything;
    // elsewhere the front end runs its normal internal sampling rate;
    // it follows next_state so it drops in the same cycle as sensing_on
    // and never shows together with the sleep flag
    wire         lp_effective;
    assign lp_effective = low_power_bit && apmc_lp_code(rate_code)
                        && (next_state == APMC_MEASURE);

    // inactivity detection
    // quiet time is counted in base ticks, so it stays exact in whole
    // seconds only while the base rate matches TICKS_PER_SEC
    // samples offered in standby are ignored outright
    wire         sample_take;  // a sample arrives while sensing
    wire         activity;     // any axis at or above the threshold
    assign sample_take = sample_valid && running;
    assign activity    = (sample_mag_x >= inactivity_threshold)
                      || (sample_mag_y >= inactivity_threshold)
                      || (sample_mag_z >= inactivity_threshold);

    // armed only with both enables while measuring
    // sleep itself is not armed, so the quiet counters clear there
    wire         armed;
    assign armed = auto_sleep_bit && link_bit && (state == APMC_MEASURE);

    logic [15:0] sec_frac;    // base ticks within the current second
    logic [7:0]  quiet_secs;  // whole quiet seconds, saturating
    logic        quiet_seen;  // at least one quiet sample since activity
    wire         sec_wrap;
    assign sec_wrap = base_tick && (sec_frac == 16'(TICKS_PER_SEC - 1));

    // quiet-time counter; any active sample restarts it from zero
    // counting is in base ticks, which only run while sensing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_frac   <= 16'h0000;
            quiet_secs <= 8'h00;
            quiet_seen <= 1'b0;
        end else if (ce) begin
            if (!armed || (sample_take && activity)) begin
                sec_frac   <= 16'h0000;
                quiet_secs <= 8'h00;
                quiet_seen <= 1'b0;
            end else begin
                if (sample_take) begin
                    quiet_seen <= 1'b1;
                end
                if (base_tick) begin
                    sec_frac <= sec_wrap ? 16'h0000 : sec_frac + 16'h0001;
                end
                // saturate so a long quiet spell cannot wrap to zero
                if (sec_wrap && (quiet_secs != 8'hFF)) begin
                    quiet_secs <= quiet_secs + 8'h01;
                end
            end
        end
    end

    // a zero duration sleeps right after the first quiet sample
    wire         quiet_done;  // quiet for the full programmed duration
    assign quiet_done = armed && quiet_seen && (quiet_secs >= inactivity_duration);

    // in sleep, an active sample wakes the core while link holds;
    // clearing either enable also wakes it, in the sequencer below
    wire         wake;
    assign wake = sample_take && activity && link_bit;

    // power-state sequencer
    // three states; standby is both the reset state and the safe
    // fallback for an illegal code
    // next state; clearing measure wins over every other cause
    // sleep returns to measure on wake or when auto-sleep is disarmed
    always_comb begin
        next_state = state;
        case (state)
            APMC_STANDBY: begin
                if (measure_bit) begin
                    next_state = APMC_MEASURE;
                end
            end
            APMC_MEASURE: begin
                if (!measure_bit) begin
                    next_state = APMC_STANDBY;
                end else if (quiet_done) begin
                    next_state = APMC_SLEEP;
                end
            end
            APMC_SLEEP: begin
                if (!measure_bit) begin
                    next_state = APMC_STANDBY;
                end else if (wake || !(auto_sleep_bit && link_bit)) begin
                    next_state = APMC_MEASURE;
                end
            end
            default: begin
                next_state = APMC_STANDBY;
            end
        endcase
    end

    // state register; reset is the supply-up entry into standby
    // ce low holds the state, as it holds every other flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= APMC_STANDBY;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // registered outputs
    // mode outputs follow next_state so all of them change together,
    // one cycle after the write that causes the change
    // the store write strobe only follows accepted samples, so standby
    // freezes the sample store rather than flushing it
    // store_write_en is the only path by which the store is written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sensing_on       <= 1'b0;
            asleep           <= 1'b0;
            low_power_active <= 1'b0;
            sample_req       <= 1'b0;
            store_write_en   <= 1'b0;
        end else if (ce) begin
            sensing_on       <= (next_state != APMC_STANDBY);
            asleep           <= (next_state == APMC_SLEEP);
            low_power_active <= lp_effective;
            sample_req       <= rate_tick && running;
            store_write_en   <= sample_take;
        end
    end

endmodule

// file: tb/apmc_top_chk.sv
// watches the power sequencer from its ports only
module apmc_top_chk #(
    parameter int BASE_DIV      = 4,
    parameter int TICKS_PER_SEC = 4
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       ce,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       sample_valid,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       sensing_on,
    input wire logic       asleep,
    input wire logic       low_power_active,
    input wire logic       sample_req,
    input wire logic       store_write_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // power control write that asks for measurement
    wire  meas_go = ce && reg_wr && (reg_addr == 6'h2D) && reg_wdata[3];
    wire  meas_stop = ce && reg_wr && (reg_addr == 6'h2D) && !reg_wdata[3];
    logic meas_go_q;    // entry takes two edges, so remember the request one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meas_go_q <= 1'b0;
        end else begin
            meas_go_q <= meas_go;
        end
    end
    chk_read_answered: assert property (ce && reg_rd |=> reg_rvalid) else $error("read not answered");
    chk_read_no_spurious: assert property (!(ce && reg_rd) |=> !reg_rvalid) else $error("stray rvalid");
    chk_rdata_held: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
    chk_measure_entry: assert property (meas_go |-> ##2 sensing_on) else $error("no measure entry");
    chk_standby_exit: assert property (meas_stop |-> ##2 (!sensing_on && !asleep))
        else $error("no return to standby");
    chk_standby_stays: assert property (!sensing_on && !meas_go && !meas_go_q |=> !sensing_on)
        else $error("left standby uncommanded");
    chk_sleep_mode: assert property (asleep |-> sensing_on && !low_power_active) else $error("bad sleep");
    chk_lp_sensing: assert property (low_power_active |-> sensing_on) else $error("lp in standby");
    chk_standby_no_req: assert property (!sensing_on [*3] |-> !sample_req) else $error("req in standby");
    chk_store_cause: assert property (store_write_en |-> $past(sample_valid)) else $error("stray store");
    chk_store_standby: assert property (sample_valid && !sensing_on |=> !store_write_en)
        else $error("store in standby");
    chk_sleep_slow: assert property (asleep && sample_req |=> !sample_req [*8]) else $error("sleep too fast");
endmodule

bind apmc_top apmc_top_chk #(.BASE_DIV(BASE_DIV), .TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (
    .clk(clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .sample_valid(sample_valid), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sensing_on(sensing_on), .asleep(asleep), .low_power_active(low_power_active),
    .sample_req(sample_req), .store_write_en(store_write_en));

// file: tb/test_accel_power_mode_control.sv
module test_accel_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BD = 4;    // small base divider keeps rate periods short
    logic       clk, arst_n, ce, reg_wr, reg_rd, sample_valid;
    logic       reg_rvalid, sensing_on, asleep, low_power_active, sample_req, store_write_en;
    logic [5:0] reg_addr, a;
    logic [7:0] reg_wdata, reg_rdata, mx, my, mz, rv, d;
    int         mismatches, total_checks, seed, n;
    logic [5:0] ra [4] = '{6'h25, 6'h26, 6'h2C, 6'h2D};    // mapped registers
    logic [7:0] rr [4] = '{8'h00, 8'h00, 8'h0A, 8'h00};    // their reset contents

    apmc_top #(.BASE_DIV(BD), .TICKS_PER_SEC(4)) i_dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .sample_valid(sample_valid), .sample_mag_x(mx), .sample_mag_y(my),
        .sample_mag_z(mz), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sensing_on(sensing_on),
        .asleep(asleep), .low_power_active(low_power_active), .sample_req(sample_req),
        .store_write_en(store_write_en));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one-byte write, strobe held for exactly one taking edge
    task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read answers at the taking edge and stands for one cycle only
    task automatic rd(input logic [5:0] ad, output logic [7:0] dt);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rvalid, 1'b1);
        dt = reg_rdata;
    endtask

    // one sample pulse, then look at the one-cycle store strobe it raises
    task automatic smp(input logic [7:0] x, input logic [7:0] z, input logic exp);
        @(posedge clk);
        sample_valid <= 1'b1;
        mx           <= x;
        my           <= 8'($random(seed)) & 8'h1F;
        mz           <= z;
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        check(store_write_en, exp);
    endtask

    // bounded wait for the sleep flag to reach a level
    task automatic wait_sleep(input logic e);
        for (int i = 0; i < 300 && asleep !== e; i++) @(posedge clk) #1;
        check(asleep, e);
    endtask

    // cycles between two request pulses; the first pulse is awaited, bounded
    task automatic period(output int p);
        for (int i = 0; i < 5000 && sample_req !== 1'b1; i++) @(posedge clk) #1;
        p = 0;
        do begin
            @(posedge clk) #1;
            p++;
        end while (sample_req !== 1'b1 && p < 5000);
    endtask

    // hang guard, well above the longest expected run
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        seed = 39796;
        mismatches = 0;
        total_checks = 0;
        arst_n = 1'b0;
        ce = 1'b1;
        {reg_wr, reg_rd, sample_valid} = 3'b000;
        {reg_addr, reg_wdata, mx, my, mz} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(sensing_on, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], rv);
            check(rv, rr[i]);
        end
        // random configuration in standby, unmapped places read back zero
        for (int i = 0; i < 24; i++) begin
            a = ra[i % 3];
            d = 8'($random(seed));
            wr(a, d);
            rd(a, rv);
            check(rv, d);
            wr({3'b110, i[2:0]}, d);
            rd({3'b110, i[2:0]}, rv);
            check(rv, 8'h00);
        end
        smp(8'hFF, 8'hFF, 1'b0);
        // rate codes 7 to F with the reduced-power bit; only 7..C take effect
        for (int c = 7; c < 16; c++) begin
            wr(6'h2C, {4'h1, 4'(c)});
            wr(6'h2D, 8'h08);
            repeat (2) @(posedge clk) #1;
            check(sensing_on, 1'b1);
            check(low_power_active, 32'(c <= 12));
            period(n);
            check(n, BD << (15 - c));
            if (c == 12) smp(8'($random(seed)), 8'h00, 1'b1);
            wr(6'h2D, 8'h00);
            repeat (2) @(posedge clk) #1;
            check(sensing_on, 1'b0);
            check(low_power_active, 1'b0);
        end
        // auto-sleep: threshold 0x20, two seconds, link missing first
        wr(6'h25, 8'h20);
        wr(6'h26, 8'h02);
        wr(6'h2C, 8'h0A);
        wr(6'h2D, 8'h18);
        smp(8'h1F, 8'h05, 1'b1);
        repeat (100) @(posedge clk) #1;
        check(asleep, 1'b0);
        wr(6'h2D, 8'h38);
        smp(8'h1F, 8'h00, 1'b1);
        check(asleep, 1'b0);
        wait_sleep(1'b1);
        rd(6'h2D, rv);
        check(rv, 8'h3C);
        rd(6'h25, rv);
        check(rv, 8'h20);
        rd(6'h26, rv);
        check(rv, 8'h02);
        period(n);
        period(n);
        check(n, BD * 512);
        smp(8'h20, 8'h00, 1'b1);
        wait_sleep(1'b0);
        smp(8'h00, 8'h1F, 1'b1);
        wait_sleep(1'b1);
        wr(6'h2D, 8'h00);
        repeat (2) @(posedge clk) #1;
        check({sensing_on, asleep}, 2'b00);
        rd(6'h2C, rv);
        check(rv, 8'h0A);
        // clock enable low: requests are not taken and the state holds
        @(posedge clk);
        ce <= 1'b0;
        wr(6'h2D, 8'h08);
        wr(6'h26, 8'h77);
        repeat (2) @(posedge clk) #1;
        check(sensing_on, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        rd(6'h26, rv);
        check(rv, 8'h02);
        // supply drop in mid-run: back to standby with reset contents
        wr(6'h2D, 8'h08);
        repeat (2) @(posedge clk) #1;
        check(sensing_on, 1'b1);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(sensing_on, 1'b0);
        rd(6'h2D, rv);
        check(rv, 8'h00);
        give_verdict();
    end
endmodule
